// [src/clock_source_control_map.svh]
// register offsets, field positions, reset values and counts for the clock source control
// assumes inclusion by bare name from the design files
`ifndef CLOCK_SOURCE_CONTROL_MAP_SVH
`define CLOCK_SOURCE_CONTROL_MAP_SVH

// ============================================================
// register offsets
`define CSC_ADDR_W             8
`define CSC_SCC0_ADDR          8'h06
`define CSC_SCC1_ADDR          8'h07
`define CSC_PROT_ADDR          8'h0a
`define CSC_STAT_ADDR          8'h0b
// ============================================================
// system_clock_control_0 fields
`define CSC_SCC0_RESET         8'h68
`define CSC_WAIT_STOP_BIT      2
`define CSC_SUB_DRIVE_BIT      3
`define CSC_SUB_PIN_BIT        4
`define CSC_MAIN_STOP_BIT      5
`define CSC_DIV_SEL0_BIT       6
`define CSC_CPU_SEL_BIT        7
// ============================================================
// system_clock_control_1 fields kept here
`define CSC_SCC1_RESET         8'h00
`define CSC_MAIN_PIN_BIT       3
`define CSC_DIV_LO_BIT         6
`define CSC_DIV_HI_BIT         7
// ============================================================
// protection and on-chip select
`define CSC_WRITE_EN_BIT       0
`define CSC_OSC_SEL_BIT        2
// ============================================================
// divider limits
`define CSC_DIV_CNT_W          4
`define CSC_HS_LIMIT_MHZ       20
`define CSC_HS_OSC_MHZ         40
`define CSC_HS_PRE_DIV         (`CSC_HS_OSC_MHZ / `CSC_HS_LIMIT_MHZ)

`endif

// [src/clock_source_control_pkg.sv]
// types for the clock source control
// assumes the map header carries every number
package clock_source_control_pkg;
  typedef enum logic [2:0] {
    DIV_1  = 3'b000,
    DIV_2  = 3'b001,
    DIV_4  = 3'b010,
    DIV_8  = 3'b011,
    DIV_16 = 3'b100
  } div_mode_t;
  typedef enum logic [1:0] {
    SW_RUN   = 2'b00,
    SW_DRAIN = 2'b01,
    SW_LOAD  = 2'b10
  } sw_state_t;
endpackage

// [src/clock_divider_tick.sv]
// ratio divider producing one-cycle enable pulses
// assumes the ratio changes only while the owner holds it stable at a boundary
`timescale 1ns/100ps
`include "clock_source_control_map.svh"
module clock_divider_tick
  import clock_source_control_pkg::*;
(
  input  wire logic                      core_clk,   // system clock
  input  wire logic                      reset_n,    // sync reset, active low
  input  wire logic                      src_tick,   // source enable
  input  wire logic [`CSC_DIV_CNT_W-1:0] ratio_m1,   // ratio minus one
  input  wire logic                      restart,    // realign count
  output logic                           tick        // divided enable
);
  logic [`CSC_DIV_CNT_W-1:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n || restart) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (src_tick) begin
      tick  <= (cnt_q == ratio_m1);
      cnt_q <= (cnt_q == ratio_m1) ? '0 : cnt_q + 1'b1;
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // clock_divider_tick

// [src/clock_source_control.sv]
// clock source control: register file, source select, division and pin sharing
// assumes sub and on-chip ticks are enables in the core_clk domain
// Function
// - wait stop bit gates peripheral clock
// - sub drive bit forced high on stop
// - sub pin switch is set-only
// - main stop bit halts main oscillator
// - external clock keeps input, buffer off
// - stopped main with pin switch low frees ports
// - division select forces divide-by-8, set on stop
// - cpu select routes system or sub clock
// - high-speed oscillator limited to 20 MHz
// - unused main oscillator frees its pins
// - unused sub oscillator frees its pins
// - division field picks 1, 2, 4, 16
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "clock_source_control_map.svh"
module clock_source_control
  import clock_source_control_pkg::*;
(
  input  wire logic                  core_clk,          // 20 MHz system clock
  input  wire logic                  reset_n,           // sync reset, active low
  input  wire logic [`CSC_ADDR_W-1:0] addr,             // register address
  input  wire logic [7:0]            wdata,             // write data
  input  wire logic                  wr_en,             // write strobe
  input  wire logic                  rd_en,             // read strobe
  output logic      [7:0]            rdata,             // read data, next cycle
  input  wire logic                  main_tick,         // main oscillator enable
  input  wire logic                  hs_tick,           // high-speed oscillator enable
  input  wire logic                  ls_tick,           // low-speed oscillator enable
  input  wire logic                  sub_tick,          // sub-clock enable
  input  wire logic                  ext_clock_mode,    // main fed by external clock
  input  wire logic                  hs_select,         // on-chip picks high-speed
  input  wire logic                  wait_mode,         // cpu in wait
  input  wire logic                  stop_entry,        // one-cycle stop entry pulse
  output logic                       cpu_clk_en,        // cpu clock enable
  output logic                       periph_clk_en,     // peripheral clock enable
  output logic                       main_osc_run,      // main oscillator buffer on
  output logic                       main_in_accept,    // main input stage enabled
  output logic                       main_pins_port,    // main pins as ports
  output logic                       sub_pins_osc,      // sub pins as oscillator
  output logic                       sub_drive_high,    // sub drive capacity high
  output logic                       switch_busy        // source or ratio change pending
);
  // ============================================================
  // registers
  logic [7:0] scc0_q;
  logic [7:0] scc1_q;
  logic       wr_enable_q;
  logic       osc_sel_q;
  logic [7:0] rdata_d;

  wire wr_ok = wr_en && wr_enable_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scc0_q <= `CSC_SCC0_RESET;
    end else begin
      if (wr_ok && addr == `CSC_SCC0_ADDR) begin
        scc0_q[1:0] <= 2'h0;
        scc0_q[`CSC_WAIT_STOP_BIT] <= wdata[`CSC_WAIT_STOP_BIT];
        scc0_q[`CSC_SUB_DRIVE_BIT] <= wdata[`CSC_SUB_DRIVE_BIT];
        scc0_q[`CSC_SUB_PIN_BIT]   <= scc0_q[`CSC_SUB_PIN_BIT] | wdata[`CSC_SUB_PIN_BIT];
        scc0_q[`CSC_MAIN_STOP_BIT] <= wdata[`CSC_MAIN_STOP_BIT];
        scc0_q[`CSC_DIV_SEL0_BIT]  <= wdata[`CSC_DIV_SEL0_BIT];
        scc0_q[`CSC_CPU_SEL_BIT]   <= wdata[`CSC_CPU_SEL_BIT];
      end
      // stop entry wins over a simultaneous write
      if (stop_entry) begin
        scc0_q[`CSC_SUB_DRIVE_BIT] <= 1'b1;
        scc0_q[`CSC_DIV_SEL0_BIT]  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scc1_q <= `CSC_SCC1_RESET;
    end else if (wr_ok && addr == `CSC_SCC1_ADDR) begin
      // main pin switch, once set, stays set
      scc1_q <= {wdata[7:6], 2'b00,
                 scc1_q[`CSC_MAIN_PIN_BIT] | wdata[`CSC_MAIN_PIN_BIT], 3'b000};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_enable_q <= 1'b0;
      osc_sel_q   <= 1'b0;
    end else if (wr_en && addr == `CSC_PROT_ADDR) begin
      wr_enable_q <= wdata[`CSC_WRITE_EN_BIT];
      osc_sel_q   <= wdata[`CSC_OSC_SEL_BIT];
    end
  end

  // ============================================================
  // read port
  always_comb begin
    rdata_d = 8'h00;
    case (addr)
      `CSC_SCC0_ADDR: rdata_d = scc0_q;
      `CSC_SCC1_ADDR: rdata_d = scc1_q;
      `CSC_PROT_ADDR: rdata_d = {5'h00, osc_sel_q, 1'b0, wr_enable_q};
      `CSC_STAT_ADDR: rdata_d = {7'h00, switch_busy};
      default:        rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= rdata_d;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ============================================================
  // division mode decode
  function automatic div_mode_t decode_div(input logic sel0, input logic [1:0] field);
    if (sel0) begin
      decode_div = DIV_8;
    end else begin
      case (field)
        2'b00:   decode_div = DIV_1;
        2'b01:   decode_div = DIV_2;
        2'b10:   decode_div = DIV_4;
        default: decode_div = DIV_16;
      endcase
    end
  endfunction

  function automatic logic [`CSC_DIV_CNT_W-1:0] ratio_of(input div_mode_t m);
    case (m)
      DIV_1:   ratio_of = 4'h0;
      DIV_2:   ratio_of = 4'h1;
      DIV_4:   ratio_of = 4'h3;
      DIV_8:   ratio_of = 4'h7;
      default: ratio_of = 4'hf;
    endcase
  endfunction

  div_mode_t req_mode;
  assign req_mode = decode_div(scc0_q[`CSC_DIV_SEL0_BIT],
                               scc1_q[`CSC_DIV_HI_BIT:`CSC_DIV_LO_BIT]);

  // ============================================================
  // source selection; the high-speed path is pre-divided to stay at the limit
  logic hs_pre_q;
  logic hs_limited;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hs_pre_q <= 1'b0;
    end else if (hs_tick) begin
      hs_pre_q <= ~hs_pre_q;
    end
  end
  assign hs_limited = hs_tick && hs_pre_q;

  logic main_runs;
  assign main_runs = !scc0_q[`CSC_MAIN_STOP_BIT] || ext_clock_mode;

  logic sys_src_tick;
  always_comb begin
    if (osc_sel_q) begin
      sys_src_tick = hs_select ? hs_limited : ls_tick;
    end else begin
      sys_src_tick = main_tick && main_runs;
    end
  end

  // ============================================================
  // glitch-free switch: a new ratio or source is taken only on a boundary of the current cpu clock, divided or sub
  sw_state_t sw_q;
  div_mode_t mode_q;
  logic      cpu_sub_q;
  logic      div_tick;
  logic      restart_q;

  clock_divider_tick u_div (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .src_tick (sys_src_tick),
    .ratio_m1 (ratio_of(mode_q)),
    .restart  (restart_q),
    .tick     (div_tick)
  );

  wire change_req = (req_mode != mode_q) || (scc0_q[`CSC_CPU_SEL_BIT] != cpu_sub_q);
  wire cur_tick   = cpu_sub_q ? sub_tick : div_tick;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sw_q      <= SW_RUN;
      mode_q    <= DIV_8;
      cpu_sub_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      case (sw_q)
        SW_RUN:   if (change_req) sw_q <= SW_DRAIN;
        SW_DRAIN: if (cur_tick) sw_q <= SW_LOAD;
        SW_LOAD: begin
          mode_q    <= req_mode;
          cpu_sub_q <= scc0_q[`CSC_CPU_SEL_BIT];
          restart_q <= 1'b1;
          sw_q      <= SW_RUN;
        end
        default:  sw_q <= SW_RUN;
      endcase
    end
  end

  // ============================================================
  // clock enables and pin control
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cpu_clk_en     <= 1'b0;
      periph_clk_en  <= 1'b0;
      main_osc_run   <= 1'b0;
      main_in_accept <= 1'b0;
      main_pins_port <= 1'b0;
      sub_pins_osc   <= 1'b0;
      sub_drive_high <= 1'b0;
      switch_busy    <= 1'b0;
    end else begin
      cpu_clk_en     <= (sw_q != SW_LOAD) && cur_tick;
      periph_clk_en  <= div_tick && !(wait_mode && scc0_q[`CSC_WAIT_STOP_BIT]);
      main_osc_run   <= !scc0_q[`CSC_MAIN_STOP_BIT];
      main_in_accept <= main_runs;
      main_pins_port <= (scc0_q[`CSC_MAIN_STOP_BIT] && !scc1_q[`CSC_MAIN_PIN_BIT])
                        || (osc_sel_q && !scc1_q[`CSC_MAIN_PIN_BIT]);
      sub_pins_osc   <= scc0_q[`CSC_SUB_PIN_BIT];
      sub_drive_high <= scc0_q[`CSC_SUB_DRIVE_BIT];
      switch_busy    <= (sw_q != SW_RUN) || change_req;
    end
  end

  // ============================================================
  // checks
  // output checks gate on reset_n in the antecedent: the edge that releases reset still
  // computes reset values, so the following cycle must not be held to the registers
  a_write_protect: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!wr_enable_q && wr_en && addr == `CSC_SCC0_ADDR && !stop_entry) |=> $stable(scc0_q))
    else $error("protected write changed control");
  a_sub_pin_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    scc0_q[`CSC_SUB_PIN_BIT] |=> scc0_q[`CSC_SUB_PIN_BIT])
    else $error("sub pin switch cleared");
  a_stop_forces: assert property (@(posedge core_clk) disable iff (!reset_n)
    stop_entry |=> scc0_q[`CSC_SUB_DRIVE_BIT] && scc0_q[`CSC_DIV_SEL0_BIT])
    else $error("stop entry did not force bits");
  a_wait_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reset_n && wait_mode && scc0_q[`CSC_WAIT_STOP_BIT]) |=> !periph_clk_en)
    else $error("peripheral clock ran in wait");
  a_main_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reset_n && scc0_q[`CSC_MAIN_STOP_BIT]) |=> !main_osc_run)
    else $error("main oscillator ran while stopped");
  a_ext_accept: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reset_n && ext_clock_mode) |=> main_in_accept)
    else $error("external clock input dropped");
  a_pins_port: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reset_n && scc0_q[`CSC_MAIN_STOP_BIT] && !scc1_q[`CSC_MAIN_PIN_BIT]) |=> main_pins_port)
    else $error("main pins not released");
  a_div8_mode: assert property (@(posedge core_clk) disable iff (!reset_n)
    scc0_q[`CSC_DIV_SEL0_BIT] |-> req_mode == DIV_8)
    else $error("divide-by-8 not selected");
  a_field_mode: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!scc0_q[`CSC_DIV_SEL0_BIT] && scc1_q[7:6] == 2'b11) |-> req_mode == DIV_16)
    else $error("divide field decode wrong");
  a_hs_limit: assert property (@(posedge core_clk) disable iff (!reset_n)
    hs_limited |=> !hs_limited)
    else $error("high-speed path above limit");
  a_sub_route: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cpu_sub_q && sw_q == SW_RUN) |=> cpu_clk_en == $past(sub_tick))
    else $error("cpu clock not from sub clock");
  a_clean_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sw_q == SW_LOAD) |-> $past(cur_tick))
    else $error("switch off boundary");
  a_sub_pins: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reset_n && scc0_q[`CSC_SUB_PIN_BIT]) |=> sub_pins_osc)
    else $error("sub pins not oscillator");
  a_main_free: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reset_n && osc_sel_q && !scc1_q[`CSC_MAIN_PIN_BIT]) |=> main_pins_port)
    else $error("main pins held on on-chip clock");
  a_busy_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reset_n && change_req) |=> switch_busy)
    else $error("pending switch not flagged");
  a_load_mode: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sw_q == SW_LOAD) |=> mode_q == $past(req_mode))
    else $error("switch loaded a stale ratio");

  // a switch ends on a tick of the old clock and suppresses the cpu edge it loads in
  sequence s_drain_end;
    sw_q == SW_DRAIN && cur_tick;
  endsequence
  sequence s_load_run;
    sw_q == SW_LOAD ##1 (sw_q == SW_RUN && !cpu_clk_en);
  endsequence
  a_switch_steps: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_drain_end |=> s_load_run)
    else $error("clock switch skipped a step");
endmodule // clock_source_control

// [verification/clock_source_control_bench.sv]
// bench for the clock source control: register access, pin sharing, division and gating
// assumes the design sits alone with its tick inputs driven from here
`timescale 1ns/100ps
`include "clock_source_control_map.svh"
module clock_source_control_bench;
  import clock_source_control_pkg::*;
  logic                   core_clk = 1'b0;
  logic                   reset_n  = 1'b0;
  logic [`CSC_ADDR_W-1:0] addr     = 8'h00;
  logic [7:0]             wdata    = 8'h00;
  logic                   wr_en    = 1'b0;
  logic                   rd_en    = 1'b0;
  logic [7:0]             rdata;
  logic                   main_tick = 1'b1;
  logic                   hs_tick   = 1'b0;
  logic                   ls_tick   = 1'b0;
  logic                   sub_tick  = 1'b0;
  logic                   ext_clock_mode = 1'b0;
  logic                   hs_select = 1'b0;
  logic                   wait_mode = 1'b0;
  logic                   stop_entry = 1'b0;
  logic                   cpu_clk_en, periph_clk_en, main_osc_run, main_in_accept;
  logic                   main_pins_port, sub_pins_osc, sub_drive_high, switch_busy;
  logic [7:0]             got;
  int                     err_count = 0;
  int                     check_count = 0;
  int                     cycles = 0;
  int                     sub_cnt = 0;
  int                     n;

  clock_source_control DUT (.core_clk(core_clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .main_tick(main_tick),
    .hs_tick(hs_tick), .ls_tick(ls_tick), .sub_tick(sub_tick),
    .ext_clock_mode(ext_clock_mode), .hs_select(hs_select), .wait_mode(wait_mode),
    .stop_entry(stop_entry), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .main_osc_run(main_osc_run), .main_in_accept(main_in_accept),
    .main_pins_port(main_pins_port), .sub_pins_osc(sub_pins_osc),
    .sub_drive_high(sub_drive_high), .switch_busy(switch_busy));

  always #25 core_clk = ~core_clk;

  // ==========================================
  // sub-clock stand-in: one enable every ten cycles
  always @(posedge core_clk) begin
    sub_cnt  <= (sub_cnt == 9) ? 0 : sub_cnt + 1;
    sub_tick <= (sub_cnt == 9);
    cycles   <= cycles + 1;
  end

  // ==========================================
  // access and compare tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp1(input string nm, input logic e, input logic g);
    cmp8(nm, {7'h00, e}, {7'h00, g});
  endtask

  task automatic cmp_rng(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a, got);
    cmp8(nm, e, got);
  endtask

  // status lags a cycle; a switch waits for a tick of the old clock before it lands
  task automatic settle();
    int k;
    repeat (3) @(posedge core_clk);
    #1;
    for (k = 0; k < 400 && switch_busy !== 1'b0; k++) begin
      @(posedge core_clk);
      #1;
    end
    cmp1("switch settled", 1'b0, switch_busy);
  endtask

  task automatic count(input int len, input logic periph, output int c);
    c = 0;
    repeat (len) begin
      @(posedge core_clk);
      #1;
      if ((periph ? periph_clk_en : cpu_clk_en) === 1'b1) c++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================
  // tests
  task automatic run_tests();
    int i;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rdchk("scc0 reset", 8'h06, 8'h68);
    rdchk("scc1 reset", 8'h07, 8'h00);
    rdchk("prot reset", 8'h0a, 8'h00);
    wr(8'h06, 8'h00);
    rdchk("locked scc0", 8'h06, 8'h68);
    $display("test reset and protection done");

    wr(8'h0a, 8'h01);
    wr(8'h06, 8'h10);
    wr(8'h06, 8'h00);
    rdchk("sub pin sticky", 8'h06, 8'h10);
    settle();
    cmp1("sub_pins_osc", 1'b1, sub_pins_osc);
    $display("test pin switch done");

    for (i = 0; i < 4; i++) begin
      wr(8'h07, {i[1:0], 6'h00});
      settle();
      count(160, 1'b0, n);
      cmp_rng("cpu div field", (160 >> (i == 3 ? 4 : i)) - 1, (160 >> (i == 3 ? 4 : i)) + 1, n);
    end
    wr(8'h06, 8'h50);
    settle();
    count(160, 1'b0, n);
    cmp_rng("cpu div8", 19, 21, n);
    $display("test division done");

    wr(8'h07, 8'h00);
    wr(8'h06, 8'h14);
    wait_mode <= 1'b1;
    settle();
    count(100, 1'b1, n);
    cmp_rng("periph gated", 0, 0, n);
    wr(8'h06, 8'h10);
    settle();
    count(100, 1'b1, n);
    cmp_rng("periph running", 99, 100, n);
    $display("test wait gating done");

    @(posedge core_clk);
    wait_mode  <= 1'b0;
    stop_entry <= 1'b1;
    @(posedge core_clk);
    stop_entry <= 1'b0;
    rdchk("stop forces", 8'h06, 8'h58);
    settle();
    cmp1("sub_drive_high", 1'b1, sub_drive_high);
    $display("test stop entry done");

    wr(8'h06, 8'h90);
    rdchk("busy status", 8'h0b, 8'h01);
    settle();
    count(160, 1'b0, n);
    cmp_rng("cpu from sub", 15, 17, n);
    rdchk("busy clear", 8'h0b, 8'h00);
    wr(8'h06, 8'h10);
    $display("test sub cpu clock done");

    // the detect bits live outside this block; only the on-chip select is set first
    hs_select <= 1'b1;
    hs_tick   <= 1'b1;
    wr(8'h0a, 8'h05);
    wr(8'h06, 8'h30);
    main_tick <= 1'b0;
    settle();
    cmp1("main_osc_run", 1'b0, main_osc_run);
    cmp1("main_pins_port", 1'b1, main_pins_port);
    count(160, 1'b0, n);
    cmp_rng("hs limited", 79, 81, n);
    // low-speed on-chip source, undivided
    @(posedge core_clk);
    hs_select      <= 1'b0;
    ls_tick        <= 1'b1;
    ext_clock_mode <= 1'b1;
    count(160, 1'b0, n);
    cmp_rng("ls source", 159, 161, n);
    wr(8'h07, 8'h08);
    wr(8'h07, 8'h00);
    settle();
    cmp1("ext pins", 1'b0, main_pins_port);
    cmp1("main_in_accept", 1'b1, main_in_accept);
    cmp1("buffer off", 1'b0, main_osc_run);
    rdchk("main pin sticky", 8'h07, 8'h08);
    wr(8'h20, 8'hff);
    rdchk("unmapped", 8'h20, 8'h00);
    rdchk("prot value", 8'h0a, 8'h05);
    $display("test main clock pins done");
  endtask

  // the tests race a cycle ceiling well above their length; whichever ends first reports
  initial begin
    fork
      run_tests();
      begin
        wait (cycles == 20000);
        err_count++;
        $display("[ERR] cycle limit expected under %0d seen %0d", 20000, cycles);
      end
    join_any
    wrap_up();
  end
endmodule // clock_source_control_bench
